// ==== sah_defs.svh ====
// Constants for the set point alarm and display block.
// Assumes readings and set points are signed display counts.
`ifndef SAH_DEFS_SVH
`define SAH_DEFS_SVH
`define SAH_READ_W 18
`define SAH_HYS_W 7
`define SAH_CAL_W 17
`define SAH_DP_W 3
`define SAH_SP_HIGH_RST 18'sh02af8
`define SAH_SP_LOW_RST (-18'sh02af8)
`define SAH_HYS_RST 7'h14
`define SAH_HYS_MAX 7'h63
`define SAH_CAL_RST 17'h02710
`define SAH_DP_RST 3'h2
`define SAH_DP_MAX 3'h5
`define SAH_OVR_NUM 8'h69
`define SAH_OVR_DEN 8'h64
`define SAH_FLASH_NS 250000000
`define SAH_CLK_NS 10
`define SAH_FLASH_CYC (`SAH_FLASH_NS / `SAH_CLK_NS)
`endif

// ==== sah_pkg.sv ====
// Types for the set point alarm and display block.
// Widths come from sah_defs.svh.
`include "sah_defs.svh"
package sah_pkg;
  typedef logic signed [`SAH_READ_W-1:0] sah_count_t;
  typedef logic [`SAH_HYS_W-1:0] sah_hys_t;
endpackage

// ==== sah_alarm_chan.sv ====
// One alarm channel: high and low latching comparators with hysteresis.
// Assumes readings arrive with a one-cycle valid strobe.
`timescale 1ns/1ps
`include "sah_defs.svh"
module sah_alarm_chan (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample,
  input wire sah_pkg::sah_count_t reading,
  input wire sah_pkg::sah_count_t spHigh,
  input wire sah_pkg::sah_count_t spLow,
  input wire sah_pkg::sah_hys_t hysHigh,
  input wire sah_pkg::sah_hys_t hysLow,
  output logic highActive,
  output logic lowActive
);
  typedef struct packed {
    logic hi;
    logic lo;
  } sah_chan_t;
  sah_chan_t st;
  sah_chan_t next_st;
  logic signed [`SAH_READ_W:0] hiRelease;
  logic signed [`SAH_READ_W:0] loRelease;
  logic signed [`SAH_READ_W:0] rd;

  always_comb begin
    rd = {reading[`SAH_READ_W-1], reading};
    hiRelease = {spHigh[`SAH_READ_W-1], spHigh} - $signed({12'h000, hysHigh});
    loRelease = {spLow[`SAH_READ_W-1], spLow} + $signed({12'h000, hysLow});
    next_st = st;
    if (sample) begin
      if (reading >= spHigh) begin
        next_st.hi = 1'b1;
      end else if (rd < hiRelease) begin
        next_st.hi = 1'b0;
      end
      if (reading <= spLow) begin
        next_st.lo = 1'b1;
      end else if (rd > loRelease) begin
        next_st.lo = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign highActive = st.hi;
  assign lowActive = st.lo;
endmodule // sah_alarm_chan

// ==== setpoint_alarm_hysteresis.sv ====
// Two-channel set point alarms, hysteresis, calibration and display control.
// Assumes a signed reading in display counts with a one-cycle valid strobe.
`timescale 1ns/1ps
`include "sah_defs.svh"
module setpoint_alarm_hysteresis #(
  parameter int FLASH_CYC = `SAH_FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic readingValid,
  input wire sah_pkg::sah_count_t reading,
  input wire logic spHighWrite1,
  input wire logic spLowWrite1,
  input wire logic spHighWrite2,
  input wire logic spLowWrite2,
  input wire sah_pkg::sah_count_t spWriteData,
  input wire logic highMarginWrite,
  input wire logic lowMarginWrite,
  input wire sah_pkg::sah_hys_t marginWriteData,
  input wire logic calWrite,
  input wire logic [`SAH_CAL_W-1:0] calWriteData,
  input wire logic fullScaleCal,
  input wire logic dpWrite,
  input wire logic [`SAH_DP_W-1:0] dpWriteData,
  output logic upper_alarm_lamp_a,
  output logic upper_alarm_lamp_b,
  output logic lower_alarm_lamp_a,
  output logic lower_alarm_lamp_b,
  output logic [3:0] alarmPinOut,
  output logic [3:0] alarmPinOe_n,
  output sah_pkg::sah_count_t displayValue,
  output logic displayBlank,
  output logic overrange,
  output logic [`SAH_DP_W-1:0] dpPosition,
  output logic [`SAH_CAL_W-1:0] activeCal,
  output sah_pkg::sah_hys_t high_release_margin,
  output sah_pkg::sah_hys_t low_release_margin
);
  localparam int FLASH_W = $clog2(FLASH_CYC + 1);

  typedef struct packed {
    sah_pkg::sah_count_t [1:0] spHigh;
    sah_pkg::sah_count_t [1:0] spLow;
    sah_pkg::sah_hys_t hysHigh;
    sah_pkg::sah_hys_t hysLow;
    logic [`SAH_CAL_W-1:0] calPending;
    logic [`SAH_CAL_W-1:0] calActive;
    logic [`SAH_DP_W-1:0] dp;
    logic [FLASH_W-1:0] flashCnt;
    logic flashOff;
    logic ovr;
    sah_pkg::sah_count_t disp;
    logic [3:0] lamps;
    logic sampled;
  } sah_state_t;

  sah_state_t st;
  sah_state_t next_st;
  logic [1:0] hiAct;
  logic [1:0] loAct;
  logic [`SAH_CAL_W+7:0] ovrLimit;
  logic [`SAH_CAL_W+7:0] magScaled;
  logic [`SAH_READ_W-1:0] mag;

  // Clamp a margin write to the legal range
  function automatic sah_pkg::sah_hys_t clamp_margin(input sah_pkg::sah_hys_t v);
    clamp_margin = (v > `SAH_HYS_MAX) ? `SAH_HYS_MAX : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      sah_alarm_chan uChan (
        .clk(clk),
        .rst(rst),
        .sample(readingValid),
        .reading(reading),
        .spHigh(st.spHigh[ch]),
        .spLow(st.spLow[ch]),
        .hysHigh(st.hysHigh),
        .hysLow(st.hysLow),
        .highActive(hiAct[ch]),
        .lowActive(loAct[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mag = reading[`SAH_READ_W-1] ? $unsigned(-reading) : $unsigned(reading);
    ovrLimit = {8'h00, st.calActive} * `SAH_OVR_NUM;
    magScaled = {7'h00, mag} * `SAH_OVR_DEN;
    next_st = st;
    if (spHighWrite1) next_st.spHigh[0] = spWriteData;
    if (spHighWrite2) next_st.spHigh[1] = spWriteData;
    if (spLowWrite1) next_st.spLow[0] = spWriteData;
    if (spLowWrite2) next_st.spLow[1] = spWriteData;
    if (highMarginWrite) next_st.hysHigh = clamp_margin(marginWriteData);
    if (lowMarginWrite) next_st.hysLow = clamp_margin(marginWriteData);
    if (calWrite) next_st.calPending = calWriteData;
    if (fullScaleCal) begin
      next_st.calActive = calWrite ? calWriteData : st.calPending;
    end
    if (dpWrite && dpWriteData <= `SAH_DP_MAX) next_st.dp = dpWriteData;
    if (readingValid) begin
      next_st.disp = reading;
      next_st.ovr = (magScaled > ovrLimit);
    end
    if (st.ovr) begin
      if (st.flashCnt >= FLASH_W'(FLASH_CYC - 1)) begin
        next_st.flashCnt = '0;
        next_st.flashOff = ~st.flashOff;
      end else begin
        next_st.flashCnt = st.flashCnt + 1'b1;
      end
    end else begin
      next_st.flashCnt = '0;
      next_st.flashOff = 1'b0;
    end
    next_st.lamps = {loAct[1], loAct[0], hiAct[1], hiAct[0]};
    next_st.sampled = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.spHigh[0] <= `SAH_SP_HIGH_RST;
      st.spHigh[1] <= `SAH_SP_HIGH_RST;
      st.spLow[0] <= `SAH_SP_LOW_RST;
      st.spLow[1] <= `SAH_SP_LOW_RST;
      st.hysHigh <= `SAH_HYS_RST;
      st.hysLow <= `SAH_HYS_RST;
      st.calPending <= `SAH_CAL_RST;
      st.calActive <= `SAH_CAL_RST;
      st.dp <= `SAH_DP_RST;
      st.flashCnt <= '0;
      st.flashOff <= 1'b0;
      st.ovr <= 1'b0;
      st.disp <= '0;
      st.lamps <= 4'h0;
      st.sampled <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp bit order: upper a, upper b, lower a, lower b
  assign upper_alarm_lamp_a = st.lamps[0];
  assign upper_alarm_lamp_b = st.lamps[1];
  assign lower_alarm_lamp_a = st.lamps[2];
  assign lower_alarm_lamp_b = st.lamps[3];
  assign alarmPinOut = 4'h0;
  assign alarmPinOe_n = ~st.lamps;
  assign displayValue = st.disp;
  assign displayBlank = st.flashOff;
  assign overrange = st.ovr;
  assign dpPosition = st.dp;
  assign activeCal = st.calActive;
  assign high_release_margin = st.hysHigh;
  assign low_release_margin = st.hysLow;
endmodule // setpoint_alarm_hysteresis

// ==== sah_checker_properties.sv ====
// Port assertions for the set point alarm block.
// Bound to setpoint_alarm_hysteresis; channel 1 set points mirrored from writes.
`timescale 1ns/1ps
`include "sah_defs.svh"
module sah_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic readingValid,
  input wire sah_pkg::sah_count_t reading,
  input wire logic spHighWrite1,
  input wire logic spLowWrite1,
  input wire sah_pkg::sah_count_t spWriteData,
  input wire logic highMarginWrite,
  input wire sah_pkg::sah_hys_t marginWriteData,
  input wire logic dpWrite,
  input wire logic [`SAH_DP_W-1:0] dpWriteData,
  input wire logic upper_alarm_lamp_a,
  input wire logic lower_alarm_lamp_a,
  input wire logic [3:0] alarmPinOut,
  input wire logic [3:0] alarmPinOe_n,
  input wire logic [`SAH_DP_W-1:0] dpPosition,
  input wire sah_pkg::sah_hys_t high_release_margin
);
  sah_pkg::sah_count_t hi;
  sah_pkg::sah_count_t lo;
  always_ff @(posedge clk) begin
    if (rst) begin
      hi <= `SAH_SP_HIGH_RST;
      lo <= `SAH_SP_LOW_RST;
    end else begin
      if (spHighWrite1) hi <= spWriteData;
      if (spLowWrite1) lo <= spWriteData;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence upHit; readingValid && reading >= hi; endsequence
  sequence loHit; readingValid && reading <= lo; endsequence
  sequence upFree;
    readingValid && reading < hi - $signed({1'b0, high_release_margin});
  endsequence
  high_set_a: assert property (upHit |-> ##2 upper_alarm_lamp_a)
    else $error("upper lamp off");
  low_set_a: assert property (loHit |-> ##2 lower_alarm_lamp_a)
    else $error("lower lamp off");
  high_release_a: assert property (upFree |-> ##2 !upper_alarm_lamp_a)
    else $error("upper lamp held");
  lamp_stable_a: assert property ($changed(upper_alarm_lamp_a) |-> $past(readingValid, 2))
    else $error("lamp moved without reading");
  pin_enable_a: assert property ({alarmPinOe_n[2], alarmPinOe_n[0]} == ~{lower_alarm_lamp_a, upper_alarm_lamp_a})
    else $error("pin enable mismatch");
  pin_ground_a: assert property (alarmPinOut == 4'h0)
    else $error("pin not grounded");
  margin_clamp_a: assert property (highMarginWrite && marginWriteData > 7'h63 |=> high_release_margin == 7'h63)
    else $error("margin not clamped");
  dp_ignore_a: assert property (dpWrite && dpWriteData > 3'h5 |=> $stable(dpPosition))
    else $error("bad decimal point taken");
endmodule // sah_checker
bind setpoint_alarm_hysteresis sah_checker chk (.clk(clk), .rst(rst), .readingValid(readingValid),
  .reading(reading), .spHighWrite1(spHighWrite1), .spLowWrite1(spLowWrite1),
  .spWriteData(spWriteData), .highMarginWrite(highMarginWrite), .marginWriteData(marginWriteData),
  .dpWrite(dpWrite), .dpWriteData(dpWriteData), .upper_alarm_lamp_a(upper_alarm_lamp_a),
  .lower_alarm_lamp_a(lower_alarm_lamp_a), .alarmPinOut(alarmPinOut),
  .alarmPinOe_n(alarmPinOe_n), .dpPosition(dpPosition), .high_release_margin(high_release_margin));

// ==== sah_load_model.sv ====
// Far side: pulled-up alarm loads on the open collector pins.
// Assumes pin output and active low enable from the block.
`timescale 1ns/1ps
module sah_load_model (
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe_n,
  output logic [3:0] pinLevel
);
  // Released pin rises to the load supply
  assign pinLevel = pinOe_n | pinOut;
endmodule // sah_load_model

// ==== sah_tb.sv ====
// Self-checking bench for the set point alarm block.
// Assumes the load model on the alarm pins.
`timescale 1ns/1ps
module tb;
  typedef struct {sah_pkg::sah_count_t rd; logic [3:0] lamps; logic ovr;} sah_row_t;
  logic clk = 0, rst = 1, rv = 0, hw2 = 0, mw = 0, cw = 0, fsc = 0, dw = 0;
  sah_pkg::sah_count_t rd = 0, sd = 0;
  sah_pkg::sah_hys_t md = 0, hm, lm;
  logic [16:0] cd = 0, acal;
  logic [2:0] dd = 0, dp;
  logic [3:0] lamp, pout, poe, level;
  logic ovr;
  int errors = 0, samples_checked = 0;
  sah_row_t rows[8] = '{'{18'sh0, 4'h0, 0}, '{18'sh2af8, 4'h3, 1}, '{18'sh2ae4, 4'h3, 1},
    '{18'sh2ae3, 4'h0, 1}, '{18'sh2af7, 4'h0, 1}, '{-18'sh2af8, 4'hc, 1},
    '{-18'sh2ae4, 4'hc, 1}, '{-18'sh2ae3, 4'h0, 1}};
  sah_pkg::sah_count_t disp;
  logic blank;
  setpoint_alarm_hysteresis #(.FLASH_CYC(4)) dut (.clk(clk), .rst(rst), .readingValid(rv),
    .reading(rd), .spHighWrite1(1'b0), .spLowWrite1(1'b0), .spHighWrite2(hw2),
    .spLowWrite2(1'b0), .spWriteData(sd), .highMarginWrite(mw), .lowMarginWrite(mw),
    .marginWriteData(md), .calWrite(cw), .calWriteData(cd), .fullScaleCal(fsc), .dpWrite(dw),
    .dpWriteData(dd), .upper_alarm_lamp_a(lamp[0]), .upper_alarm_lamp_b(lamp[1]),
    .lower_alarm_lamp_a(lamp[2]), .lower_alarm_lamp_b(lamp[3]), .alarmPinOut(pout),
    .alarmPinOe_n(poe), .displayValue(disp), .displayBlank(blank), .overrange(ovr),
    .dpPosition(dp),
    .activeCal(acal), .high_release_margin(hm), .low_release_margin(lm));
  sah_load_model load (.pinOut(pout), .pinOe_n(poe), .pinLevel(level));
  always #5 clk = ~clk;
  task automatic check(string name, logic [17:0] exp, logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdg(sah_pkg::sah_count_t v);
    @(posedge clk) #1 rd = v;
    rv = 1;
    @(posedge clk) #1 rv = 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    foreach (rows[i]) begin
      rdg(rows[i].rd);
      check("lamps", rows[i].lamps, lamp);
      check("pins", rows[i].lamps ^ 4'hf, level);
      check("overrange", rows[i].ovr, ovr);
    end
    @(posedge clk) #1 mw = 1;
    md = 7'h78;
    @(posedge clk) #1 md = 7'h0;
    check("clamp", 18'h31e3, {hm, lm});
    @(posedge clk) #1 mw = 0;
    check("margin", 18'h0, {hm, lm});
    @(posedge clk) #1 dw = 1;
    dd = 3'h6;
    @(posedge clk) #1 dd = 3'h5;
    check("dp bad", 18'h2, dp);
    @(posedge clk) #1 dw = 0;
    check("dp", 18'h5, dp);
    @(posedge clk) #1 cw = 1;
    cd = 17'h4e20;
    @(posedge clk) #1 cw = 0;
    fsc = 1;
    check("cal held", 18'h2710, acal);
    @(posedge clk) #1 fsc = 0;
    check("cal", 18'h4e20, acal);
    @(posedge clk) #1 hw2 = 1;
    sd = 18'sh1f4;
    @(posedge clk) #1 hw2 = 0;
    rdg(18'sh2af8);
    check("over", 18'h0, ovr);
    rdg(18'sh258);
    check("lamps", 18'h2, lamp);
    @(posedge clk) #1 rst = 1;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    check("rst margin", 18'ha14, {hm, lm});
    check("rst dp", 18'h2, dp);
    check("rst cal", 18'h2710, acal);
    check("rst disp", 18'h0, disp);
    check("rst blank", 18'h0, blank);
    rdg(18'sh258);
    check("rst lamps", 18'h0, lamp);
    check("disp", 18'h258, disp);
    rdg(18'sh2af8);
    check("disp over", 18'h2af8, disp);
    check("blank on", 18'h0, blank);
    repeat (2) @(posedge clk);
    #1;
    check("blank off", 18'h1, blank);
    repeat (4) @(posedge clk);
    #1;
    check("blank back", 18'h0, blank);
    report_and_stop();
  end
  initial begin
    #5000;
    errors++;
    report_and_stop();
  end
endmodule // tb
